// File: hdl/emr_regs.sv
// emr_regs: read-only measurement register bank with pulse output and reset hold
// assumes measurement words arrive on sys_clk from the datapath with an update strobe
// Overview of operation
// - apparent power words are 16 bits with the top bit forced to zero
// - n line current rms is unsigned 16 bits, three fractional digits
// - n line active power is two's complement, sign on top
// - n line reactive power is two's complement, sign on top
// - power factor is sign plus magnitude, magnitude at most 1.000
// - phase angle is signed, clamped to plus or minus 180.0 degrees
// - pulse width 80 ms if period at least 160 ms, else half period
// - uart rate 2400 or 9600 detected automatically
// - logic held in reset 5 ms after power-on before operating
`timescale 1ns/1ps
module emr_regs
  import emr_pkg::*;
#(
  parameter int unsigned POR_CNT    = POR_CYCLES,
  parameter int unsigned WIDE_CNT   = PULSE_WIDE_CYCLES,
  parameter int unsigned LONG_CNT   = PULSE_LONG_CYCLES,
  parameter int unsigned PER_W      = 24
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire emr_meas_t   meas_in,
  input  wire logic        meas_update,
  input  wire emr_req_t    req,
  input  wire logic        energy_tick,
  input  wire logic        uart_rx_pin,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output logic             energy_pulse_out,
  output logic             ready,
  output logic             baud_locked,
  output logic             baud_fast
);

  initial begin
    if (POR_CNT < 1 || WIDE_CNT < 1 || LONG_CNT < 2 * WIDE_CNT - 1)
      $error("emr_regs: bad timing parameters");
    if (PER_W < $clog2(LONG_CNT + 1) || PER_W < $clog2(POR_CNT + 1))
      $error("emr_regs: period counter too narrow");
  end

  // ---------- power-on hold ----------
  logic [PER_W-1:0] por_cnt;
  logic             run;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      por_cnt <= '0;
      run     <= 1'b0;
    end else if (clk_en && !run) begin
      if (por_cnt == PER_W'(POR_CNT - 1)) run <= 1'b1;
      else por_cnt <= por_cnt + 1'b1;
    end
  end

  // ---------- format conditioning ----------
  function automatic logic [15:0] clamp_pf(input logic [15:0] v);
    logic [14:0] mag;
    mag = v[14:0];
    if ({1'b0, mag} > PF_MAG_MAX) mag = PF_MAG_MAX[14:0];
    return {v[SIGN_BIT], mag};
  endfunction : clamp_pf

  function automatic logic [15:0] clamp_angle(input logic [15:0] v);
    if (!v[SIGN_BIT] && v > ANGLE_POS_MAX) return ANGLE_POS_MAX;
    if (v[SIGN_BIT] && v < ANGLE_NEG_MIN) return ANGLE_NEG_MIN;
    return v;
  endfunction : clamp_angle

  emr_meas_t bank;
  emr_meas_t next_bank;

  assign next_bank.l_apparent = {1'b0, meas_in.l_apparent[14:0]};
  assign next_bank.n_apparent = {1'b0, meas_in.n_apparent[14:0]};
  assign next_bank.n_current  = meas_in.n_current;
  assign next_bank.n_active   = meas_in.n_active;
  assign next_bank.n_reactive = meas_in.n_reactive;
  assign next_bank.n_pf       = clamp_pf(meas_in.n_pf);
  assign next_bank.n_angle    = clamp_angle(meas_in.n_angle);

  // bank only changes on datapath updates; bus writes never reach it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank <= '0;
    end else if (clk_en && run && meas_update) begin
      bank <= next_bank;
    end
  end

  // ---------- read port ----------
  wire logic [15:0] sel_data =
    (req.addr == ADDR_L_APPARENT) ? bank.l_apparent :
    (req.addr == ADDR_N_CURRENT)  ? bank.n_current  :
    (req.addr == ADDR_N_ACTIVE)   ? bank.n_active   :
    (req.addr == ADDR_N_REACTIVE) ? bank.n_reactive :
    (req.addr == ADDR_N_PF)       ? bank.n_pf       :
    (req.addr == ADDR_N_ANGLE)    ? bank.n_angle    :
    (req.addr == ADDR_N_APPARENT) ? bank.n_apparent : RESET_VALUE;
  wire logic rd_hit = req.valid && !req.write && run;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data  <= RESET_VALUE;
      rd_valid <= 1'b0;
      ready    <= 1'b0;
    end else if (clk_en) begin
      ready    <= run;
      rd_valid <= rd_hit;
      if (rd_hit) rd_data <= sel_data;
    end
  end

  // ---------- energy pulse shaping ----------
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_HIGH = 2'b01,
    PS_LOW  = 2'b10
  } emr_pstate_t;

  emr_pstate_t      pstate;
  emr_pstate_t      next_pstate;
  logic [PER_W-1:0] period_cnt;
  logic [PER_W-1:0] last_period;
  logic [PER_W-1:0] high_cnt;
  logic             seen_tick;

  // width from the previous tick spacing: short periods get half, long get full
  wire logic [PER_W-1:0] half_period = last_period >> 1;
  wire logic long_period = !seen_tick || (last_period >= PER_W'(LONG_CNT));
  wire logic [PER_W-1:0] target_w =
    long_period ? PER_W'(WIDE_CNT) : ((half_period == '0) ? PER_W'(1) : half_period);
  wire logic tick_go = run && energy_tick;

  always_comb begin
    next_pstate = pstate;
    case (pstate)
      PS_IDLE: if (tick_go) next_pstate = PS_HIGH;
      PS_HIGH: if (high_cnt + 1'b1 >= target_w) next_pstate = PS_LOW;
      PS_LOW:  if (tick_go) next_pstate = PS_HIGH;
      default: next_pstate = PS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pstate           <= PS_IDLE;
      period_cnt       <= '0;
      last_period      <= '0;
      high_cnt         <= '0;
      seen_tick        <= 1'b0;
      energy_pulse_out <= 1'b0;
    end else if (clk_en) begin
      pstate <= next_pstate;
      if (tick_go) begin
        last_period <= period_cnt;
        seen_tick   <= (pstate != PS_IDLE) || seen_tick;
        period_cnt  <= PER_W'(1);
      end else if (period_cnt != {PER_W{1'b1}}) begin
        period_cnt <= period_cnt + 1'b1;
      end
      high_cnt         <= (next_pstate == PS_HIGH && pstate == PS_HIGH) ? high_cnt + 1'b1 : '0;
      energy_pulse_out <= (next_pstate == PS_HIGH);
    end
  end

  // ---------- uart rate detection ----------
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else if (clk_en) begin
      rx_meta <= uart_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  logic lock_i;
  logic fast_i;

  emr_uart_baud #(
    .CNT_W (PER_W)
  ) u_baud (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .clk_en      (clk_en && run),
    .rx_sync     (rx_sync),
    .baud_locked (lock_i),
    .baud_fast   (fast_i)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      baud_locked <= 1'b0;
      baud_fast   <= 1'b0;
    end else if (clk_en) begin
      baud_locked <= lock_i;
      baud_fast   <= fast_i;
    end
  end

  // ---------- checks ----------
  property p_app_top;
    @(posedge sys_clk) disable iff (srst)
      !bank.l_apparent[SIGN_BIT] && !bank.n_apparent[SIGN_BIT];
  endproperty
  a_app_top: assert property (p_app_top) else $error("apparent top bit set");

  property p_cur_copy;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && run && meas_update) |=> bank.n_current == $past(meas_in.n_current);
  endproperty
  a_cur_copy: assert property (p_cur_copy) else $error("current not stored");

  property p_act_copy;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && run && meas_update) |=> bank.n_active == $past(meas_in.n_active)
        && bank.n_reactive == $past(meas_in.n_reactive);
  endproperty
  a_act_copy: assert property (p_act_copy) else $error("power not stored");

  property p_react_sign;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && run && meas_update) |=>
        bank.n_reactive[SIGN_BIT] == $past(meas_in.n_reactive[SIGN_BIT]);
  endproperty
  a_react_sign: assert property (p_react_sign) else $error("reactive sign lost");

  property p_pf_range;
    @(posedge sys_clk) disable iff (srst)
      {1'b0, bank.n_pf[14:0]} <= PF_MAG_MAX;
  endproperty
  a_pf_range: assert property (p_pf_range) else $error("pf out of range");

  property p_angle_range;
    @(posedge sys_clk) disable iff (srst)
      $signed(bank.n_angle) <= $signed(ANGLE_POS_MAX)
        && $signed(bank.n_angle) >= $signed(ANGLE_NEG_MIN);
  endproperty
  a_angle_range: assert property (p_angle_range) else $error("angle out of range");

  property p_pulse_cap;
    @(posedge sys_clk) disable iff (srst)
      high_cnt < PER_W'(WIDE_CNT);
  endproperty
  a_pulse_cap: assert property (p_pulse_cap) else $error("pulse too wide");

  property p_por_hold;
    @(posedge sys_clk) disable iff (srst)
      !run |-> !ready && !rd_valid && !energy_pulse_out;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("active during hold");

  property p_read_stable;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && rd_hit && !meas_update) |=> rd_valid && rd_data == $past(sel_data)
        && bank == $past(bank);
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("read altered bank");

endmodule : emr_regs

// File: pkg/emr_pkg.sv
// emr_pkg: constants and carrier types for the measurement register bank
// assumes a 20 MHz system clock; all timing counts derive from it
package emr_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned POR_DELAY_MS  = 5;
  localparam int unsigned POR_CYCLES    = (POR_DELAY_MS * (CLK_HZ / 1000));
  localparam int unsigned PULSE_WIDE_MS = 80;
  localparam int unsigned PULSE_WIDE_CYCLES = PULSE_WIDE_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_LONG_MS = 160;
  localparam int unsigned PULSE_LONG_CYCLES = PULSE_LONG_MS * (CLK_HZ / 1000);

  localparam int unsigned BAUD_SLOW     = 2400;
  localparam int unsigned BAUD_FAST     = 9600;
  localparam int unsigned BIT_SLOW_CYC  = CLK_HZ / BAUD_SLOW;
  localparam int unsigned BIT_FAST_CYC  = CLK_HZ / BAUD_FAST;
  localparam int unsigned BAUD_SPLIT    = (BIT_SLOW_CYC + BIT_FAST_CYC) / 2;

  localparam int unsigned SPI_MIN_BPS   = 200;
  localparam int unsigned SPI_MAX_BPS   = 160_000;

  localparam logic [6:0] ADDR_L_APPARENT  = 7'h4f;
  localparam logic [6:0] ADDR_N_CURRENT   = 7'h68;
  localparam logic [6:0] ADDR_N_ACTIVE    = 7'h6a;
  localparam logic [6:0] ADDR_N_REACTIVE  = 7'h6b;
  localparam logic [6:0] ADDR_N_PF        = 7'h6d;
  localparam logic [6:0] ADDR_N_ANGLE     = 7'h6e;
  localparam logic [6:0] ADDR_N_APPARENT  = 7'h6f;

  localparam logic [15:0] RESET_VALUE     = 16'h0000;
  localparam logic [15:0] APPARENT_MAX    = 16'h7fff;
  localparam logic [15:0] PF_MAG_MAX      = 16'h03e8;
  localparam logic [15:0] ANGLE_POS_MAX   = 16'h0708;
  localparam logic [15:0] ANGLE_NEG_MIN   = 16'hf8f8;
  localparam int unsigned SIGN_BIT        = 15;

  typedef struct packed {
    logic [15:0] l_apparent;
    logic [15:0] n_current;
    logic [15:0] n_active;
    logic [15:0] n_reactive;
    logic [15:0] n_pf;
    logic [15:0] n_angle;
    logic [15:0] n_apparent;
  } emr_meas_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
  } emr_req_t;

endpackage : emr_pkg

// File: hdl/emr_uart_baud.sv
// emr_uart_baud: measures the first start bit on the uart line and picks the rate
// assumes the line input is already synchronised to sys_clk
`timescale 1ns/1ps
module emr_uart_baud
  import emr_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic rx_sync,
  output logic      baud_locked,
  output logic      baud_fast
);

  initial begin
    if (CNT_W < $clog2(BIT_SLOW_CYC + 1)) $error("emr_uart_baud: counter too narrow");
  end

  logic             rx_prev;
  logic             measuring;
  logic [CNT_W-1:0] low_cnt;

  wire fall = rx_prev & ~rx_sync;
  wire rise = ~rx_prev & rx_sync;
  wire short_bit = (low_cnt < CNT_W'(BAUD_SPLIT));

  // first low pulse after reset is a start bit followed by a one; its width sets rate
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_prev     <= 1'b1;
      measuring   <= 1'b0;
      low_cnt     <= '0;
      baud_locked <= 1'b0;
      baud_fast   <= 1'b0;
    end else if (clk_en) begin
      rx_prev <= rx_sync;
      if (!baud_locked && fall) begin
        measuring <= 1'b1;
        low_cnt   <= '0;
      end else if (measuring && rise) begin
        measuring   <= 1'b0;
        baud_locked <= 1'b1;
        baud_fast   <= short_bit;
      end else if (measuring && low_cnt != {CNT_W{1'b1}}) begin
        low_cnt <= low_cnt + 1'b1;
      end
    end
  end

  property p_lock_on_rise;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && measuring && rise && !fall) |=> baud_locked;
  endproperty
  a_lock_on_rise: assert property (p_lock_on_rise) else $error("baud not locked");

endmodule : emr_uart_baud

// File: tb/emr_host_model.sv
// emr_host_model: host stand-in that issues single register requests
// assumes the device samples req on each rising edge of sys_clk
`timescale 1ns/1ps
module emr_host_model
  import emr_pkg::*;
(
  input  wire logic        sys_clk,
  output emr_req_t         req,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  initial req = '0;

  // one edge per request, idle edge between calls keeps host pacing modest
  task automatic access(input logic wr, input logic [6:0] a, output logic [15:0] d,
                        output logic v);
    @(posedge sys_clk) #2;
    req = '{valid: 1'b1, write: wr, addr: a};
    @(posedge sys_clk) #2;
    v = rd_valid;
    d = rd_data;
    req = '0;
  endtask : access
endmodule : emr_host_model

// File: tb/energy_meter_measurement_regs_tb.sv
// energy_meter_measurement_regs_tb: register reads, pulse widths, rate detect
// assumes short hold and pulse counts set through emr_regs parameters
`timescale 1ns/1ps
module energy_meter_measurement_regs_tb
  import emr_pkg::*;
;
  localparam int POR  = 20;
  localparam int WIDE = 8;
  localparam int LONG = 16;

  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_en = 1'b1;
  emr_meas_t   meas_in = '0;
  logic        meas_update = 1'b0;
  emr_req_t    req;
  logic        energy_tick = 1'b0;
  logic        uart_rx_pin = 1'b1;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        energy_pulse_out;
  logic        ready;
  logic        baud_locked;
  logic        baud_fast;
  int          fails = 0;
  int          total_checks = 0;
  logic [6:0]  addrs [7] = '{ADDR_L_APPARENT, ADDR_N_CURRENT, ADDR_N_ACTIVE, ADDR_N_REACTIVE,
                             ADDR_N_PF, ADDR_N_ANGLE, ADDR_N_APPARENT};
  // inputs and their conditioned images, same order as addrs
  logic [15:0] in1 [7] = '{16'hffff, 16'hffff, 16'h8000, 16'h7fff, 16'h83e9, 16'hf000, 16'h8001};
  logic [15:0] ex1 [7] = '{16'h7fff, 16'hffff, 16'h8000, 16'h7fff, 16'h83e8, 16'hf8f8, 16'h0001};
  logic [15:0] in2 [7] = '{16'h0001, 16'h1234, 16'h7fff, 16'h8000, 16'h03f0, 16'h0709, 16'h7fff};
  logic [15:0] ex2 [7] = '{16'h0001, 16'h1234, 16'h7fff, 16'h8000, 16'h03e8, 16'h0708, 16'h7fff};

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  emr_regs #(.POR_CNT(POR), .WIDE_CNT(WIDE), .LONG_CNT(LONG)) u_emr_regs (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .meas_in(meas_in),
    .meas_update(meas_update), .req(req), .energy_tick(energy_tick),
    .uart_rx_pin(uart_rx_pin), .rd_data(rd_data), .rd_valid(rd_valid),
    .energy_pulse_out(energy_pulse_out), .ready(ready), .baud_locked(baud_locked),
    .baud_fast(baud_fast));

  emr_host_model u_emr_host_model (
    .sys_clk(sys_clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    u_emr_host_model.access(1'b0, a, d, v);
    check("rd_valid", {15'h0, v}, 16'h0001);
    check("rd_data", d, exp);
  endtask : rd

  task automatic rst();
    int k;
    srst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2 srst = 1'b0;
    check("outs_after_reset", {12'h0, ready, rd_valid, energy_pulse_out, baud_locked}, 16'h0);
    repeat (POR - 1) @(posedge sys_clk);
    #2 check("ready_held", {15'h0, ready}, 16'h0);
    k = 0;
    while (ready !== 1'b1 && k < 8) begin
      @(posedge sys_clk) #2;
      k++;
    end
    check("ready", {15'h0, ready}, 16'h0001);
  endtask : rst

  task automatic upd(input logic [15:0] w [7], input logic [15:0] e [7]);
    @(posedge sys_clk) #2;
    meas_in = {w[0], w[1], w[2], w[3], w[4], w[5], w[6]};
    meas_update = 1'b1;
    @(posedge sys_clk) #2;
    meas_update = 1'b0;
    // reads of the whole bank, one idle edge between requests
    for (int i = 0; i < 7; i++) rd(addrs[i], e[i]);
  endtask : upd

  // tick spacing s edges; width follows spacing p ahead of this tick, 0 for the first tick
  task automatic pulse(input int s, input int p);
    int n;
    n = 0;
    @(posedge sys_clk) #2;
    energy_tick = 1'b1;
    @(posedge sys_clk) #2;
    energy_tick = 1'b0;
    repeat (s - 2) begin
      n += (energy_pulse_out === 1'b1);
      @(posedge sys_clk) #2;
    end
    check("pulse_width", 16'(n), 16'((p == 0 || p >= LONG) ? WIDE : p / 2));
  endtask : pulse

  task automatic baud(input int w, input logic fast);
    uart_rx_pin = 1'b0;
    repeat (w) @(posedge sys_clk);
    #2 uart_rx_pin = 1'b1;
    repeat (10) @(posedge sys_clk);
    #2 check("baud", {14'h0, baud_locked, baud_fast}, {14'h0, 1'b1, fast});
  endtask : baud

  initial begin
    logic [15:0] d;
    logic        v;
    rst();
    rd(ADDR_N_ANGLE, 16'h0000);
    upd(in1, ex1);
    upd(in2, ex2);
    // writes carry no effect and return nothing
    u_emr_host_model.access(1'b1, ADDR_N_ACTIVE, d, v);
    check("wr_no_valid", {15'h0, v}, 16'h0);
    rd(ADDR_N_ACTIVE, 16'h7fff);
    rd(ADDR_N_ACTIVE, 16'h7fff);
    rd(7'h10, 16'h0000);
    // frozen clock enable: no answer, read port keeps its last word
    @(posedge sys_clk) #2;
    clk_en = 1'b0;
    u_emr_host_model.access(1'b0, ADDR_N_CURRENT, d, v);
    clk_en = 1'b1;
    check("frozen_valid", {15'h0, v}, 16'h0);
    check("frozen_data", d, 16'h0000);
    pulse(20, 0);
    pulse(20, 20);
    pulse(10, 20);
    pulse(20, 10);
    baud(BIT_FAST_CYC, 1'b1);
    rst();
    baud(BIT_SLOW_CYC, 1'b0);
    stop_test();
  end

  // whole run is near 10.6k cycles; margin covers slow rate detection
  initial begin
    #(60_000 * 50);
    fails++;
    stop_test();
  end
endmodule : energy_meter_measurement_regs_tb
